// File: rtl/por_seq_pkg.sv
// Shared constants and types for the power-on reset sequencer pair
package por_seq_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned PWR_STABLE_US   = 2000;
  localparam int unsigned HUB_RESET_US    = 1000;
  localparam int unsigned PROC_TIMER_US   = 1000;
  localparam int unsigned CORE_REL_MIN    = 4;
  localparam int unsigned CORE_REL_MAX    = 6;
  localparam int unsigned PWR_STABLE_CYC  = (PWR_STABLE_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int unsigned HUB_RESET_CYC   = (HUB_RESET_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PROC_TIMER_CYC  = (PROC_TIMER_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CLK_ALIGN_DIV   = 2;
  localparam int unsigned TIMER_W         = 24;

  // Handshake line codes: device requests, far end acknowledges
  localparam logic [1:0] HS_IDLE = 2'h0;
  localparam logic [1:0] HS_REQ  = 2'h1;
  localparam logic [1:0] HS_ACK  = 2'h2;

  typedef enum logic [2:0] {
    DEV_HELD    = 3'b000,
    DEV_ALIGN   = 3'b001,
    DEV_TIMING  = 3'b010,
    DEV_HS_REQ  = 3'b011,
    DEV_RUN     = 3'b100
  } dev_state_t;

  typedef enum logic [1:0] {
    HUB_OFF     = 2'b00,
    HUB_STABLE  = 2'b01,
    HUB_RESET   = 2'b10,
    HUB_RUN     = 2'b11
  } hub_state_t;
endpackage

// File: rtl/por_link_if.sv
// Interface joining the reset sequencer and its companion hub
`timescale 1ns/1ps
interface por_link_if;
  import por_seq_pkg::*;
  logic       power_good_in;
  logic       reset_request_in_n;
  logic [1:0] hub_handshake_dev;
  logic [1:0] hub_handshake_lines;

  modport device (
    input  power_good_in,
    input  reset_request_in_n,
    input  hub_handshake_lines,
    output hub_handshake_dev
  );
  modport hub (
    output power_good_in,
    output reset_request_in_n,
    output hub_handshake_lines,
    input  hub_handshake_dev
  );
endinterface

// File: rtl/por_companion_hub.sv
// Companion end: platform power-good and hub reset output timing
`timescale 1ns/1ps
module por_companion_hub
  import por_seq_pkg::*;
#(
  parameter int unsigned PWR_CYC = PWR_STABLE_CYC,
  parameter int unsigned RST_CYC = HUB_RESET_CYC
) (
  input  wire logic core_clk,     // System clock
  input  wire logic rst,          // Synchronous reset
  input  wire logic supply_ok,    // Supplies within tolerance
  output logic      hub_reset_out_n, // Hub reset, mirrors request pin
  por_link_if.hub   link          // Link to the sequencer
);
  hub_state_t         state;
  hub_state_t         next_state;
  logic [TIMER_W-1:0] count;
  logic               count_done;
  logic               pg;
  logic               rq_n;
  logic [1:0]         ack;

  assign count_done = (state == HUB_STABLE) ? (count >= TIMER_W'(PWR_CYC - 1))
                                            : (count >= TIMER_W'(RST_CYC - 1));

  always_comb begin
    next_state = state;
    case (state)
      HUB_OFF:    next_state = supply_ok ? HUB_STABLE : HUB_OFF;
      HUB_STABLE: next_state = !supply_ok ? HUB_OFF : (count_done ? HUB_RESET : HUB_STABLE);
      HUB_RESET:  next_state = !supply_ok ? HUB_OFF : (count_done ? HUB_RUN : HUB_RESET);
      HUB_RUN:    next_state = supply_ok ? HUB_RUN : HUB_OFF;
      default:    next_state = HUB_OFF;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= HUB_OFF;
      count <= '0;
    end else begin
      state <= next_state;
      count <= (next_state != state) ? '0 : count + TIMER_W'(1);
    end
  end

  // Acknowledge the special cycle only while the device requests it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pg   <= 1'b0;
      rq_n <= 1'b0;
      ack  <= HS_IDLE;
    end else begin
      pg   <= (next_state == HUB_RESET) || (next_state == HUB_RUN);
      rq_n <= (next_state == HUB_RUN);
      ack  <= (link.hub_handshake_dev == HS_REQ && state == HUB_RUN) ? HS_ACK : HS_IDLE;
    end
  end

  assign link.power_good_in       = pg;
  assign link.reset_request_in_n  = rq_n;
  assign link.hub_handshake_lines = ack;
  assign hub_reset_out_n          = rq_n;
endmodule

// File: rtl/por_sequencer.sv
// Device end: internal reset release and processor reset timing
`timescale 1ns/1ps
module por_sequencer
  import por_seq_pkg::*;
#(
  parameter int unsigned TIMER_CYC = PROC_TIMER_CYC
) (
  input  wire logic core_clk,              // Host clock
  input  wire logic rst,                   // Synchronous reset
  por_link_if.device link,                 // Link to the companion hub
  output logic      power_on_reset,        // Clears everything, sticky bits too
  output logic      hard_reset,            // Clears all but sticky bits
  output logic      core_reset,            // Core logic reset
  output logic      processor_reset_out_n, // Processor complex reset
  output logic      clk_align              // Common edge of internal clocks
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two synchroniser flops plus the cycle that enters alignment
  localparam int unsigned SYNC_LAT = 3;

  logic               pg_meta;
  logic               pg_sync;
  logic               rq_meta;
  logic               rq_sync_n;
  dev_state_t         state;
  dev_state_t         next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic [2:0]         align_cnt;
  logic [2:0]         next_align_cnt;
  logic [1:0]         div_cnt;
  logic [1:0]         next_div_cnt;
  logic               timer_done;
  logic               align_ok;
  logic               common_edge;
  logic               ack_seen;
  logic               hold_state;
  logic               next_in_reset;
  logic               next_proc_run;
  logic [1:0]         next_hs;
  logic [1:0]         hs_out;

  // True in every state where the core logic must stay in reset
  function automatic logic reset_stage(input dev_state_t s);
    return (s == DEV_HELD) || (s == DEV_ALIGN);
  endfunction

  // Power-good has no relation to the clock, so it is never used raw
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pg_meta <= 1'b0;
      pg_sync <= 1'b0;
    end else begin
      pg_meta <= link.power_good_in;
      pg_sync <= pg_meta;
    end
  end

  // Reads as a request until two clean samples say otherwise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rq_meta   <= 1'b0;
      rq_sync_n <= 1'b0;
    end else begin
      rq_meta   <= link.reset_request_in_n;
      rq_sync_n <= rq_meta;
    end
  end

  // ----------------------------------------------------------------
  // Common-edge divider for the slower internal clocks
  // ----------------------------------------------------------------
  assign common_edge  = (div_cnt == 2'(CLK_ALIGN_DIV - 1));
  assign next_div_cnt = common_edge ? '0 : div_cnt + 2'(1);

  // Held at phase zero without power, so every power-up starts in step
  always_ff @(posedge core_clk) begin
    if (rst || !pg_sync) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------
  // The wait counts from the synchronised edge; the synchroniser latency
  // plus at most one divider period keeps the total inside 4-6 clocks.
  assign align_ok       = (align_cnt >= 3'(CORE_REL_MIN - SYNC_LAT)) && common_edge;
  assign timer_done     = (timer >= TIMER_W'(TIMER_CYC - 1));
  assign ack_seen       = (link.hub_handshake_lines == HS_ACK);
  assign hold_state     = (state == DEV_HELD);
  // Timer runs from the request release, so alignment counts toward it
  assign next_timer     = hold_state ? '0 : (timer_done ? timer : timer + TIMER_W'(1));
  assign next_align_cnt = (state == DEV_ALIGN) ? align_cnt + 3'(1) : '0;

  always_comb begin
    next_state = state;
    case (state)
      DEV_HELD:   next_state = rq_sync_n ? DEV_ALIGN : DEV_HELD;
      DEV_ALIGN:  next_state = align_ok ? DEV_TIMING : DEV_ALIGN;
      DEV_TIMING: next_state = timer_done ? DEV_HS_REQ : DEV_TIMING;
      DEV_HS_REQ: next_state = ack_seen ? DEV_RUN : DEV_HS_REQ;
      DEV_RUN:    next_state = DEV_RUN;
      default:    next_state = DEV_HELD;
    endcase
    if (!rq_sync_n) begin
      next_state = DEV_HELD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !pg_sync) begin
      state     <= DEV_HELD;
      timer     <= '0;
      align_cnt <= '0;
    end else begin
      state     <= next_state;
      timer     <= next_timer;
      align_cnt <= next_align_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Reset outputs
  // ----------------------------------------------------------------
  assign next_in_reset = reset_stage(next_state);
  assign next_proc_run = (next_state == DEV_RUN) && pg_sync;
  assign next_hs       = (next_state == DEV_HS_REQ) ? HS_REQ : HS_IDLE;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_on_reset <= 1'b1;
    end else begin
      power_on_reset <= !pg_sync;
    end
  end

  // One source for both, so they can never release a cycle apart
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hard_reset <= 1'b1;
      core_reset <= 1'b1;
    end else begin
      hard_reset <= next_in_reset;
      core_reset <= next_in_reset;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      processor_reset_out_n <= 1'b0;
    end else begin
      processor_reset_out_n <= next_proc_run;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hs_out <= HS_IDLE;
    end else begin
      hs_out <= next_hs;
    end
  end

  assign clk_align              = common_edge;
  assign link.hub_handshake_dev = hs_out;
endmodule

// File: test/por_monitor.sv
// Checker for the reset sequencer link
`timescale 1ns/1ps
module por_monitor
  import por_seq_pkg::*;
#(
  parameter int TIMER_CYC = 20,
  parameter int RST_CYC   = 20
) (
  input wire logic       core_clk,              // Clock
  input wire logic       rst,                   // Reset
  input wire logic       power_good_in,         // Link
  input wire logic       reset_request_in_n,    // Link
  input wire logic [1:0] hub_handshake_dev,     // Link
  input wire logic [1:0] hub_handshake_lines,   // Link
  input wire logic       power_on_reset,        // Device
  input wire logic       hard_reset,            // Device
  input wire logic       core_reset,            // Device
  input wire logic       processor_reset_out_n, // Device
  input wire logic       clk_align              // Device
);
  logic [15:0] up_cnt;
  logic        hs_seen;

  // Cycles since the request was released
  always_ff @(posedge core_clk) begin
    if (rst || !reset_request_in_n) begin
      up_cnt  <= 16'h0;
      hs_seen <= 1'b0;
    end else begin
      up_cnt <= up_cnt + 16'h1;
      if (hub_handshake_lines == HS_ACK) begin
        hs_seen <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ----
  // Properties
  // ----
  property p_hub_rst;
    $rose(power_good_in) |-> ##RST_CYC $rose(reset_request_in_n);
  endproperty
  a_hub_rst: assert property (p_hub_rst) else $error("hub reset hold");
  property p_core;
    $rose(reset_request_in_n) |-> core_reset [*4] ##[1:3] !core_reset;
  endproperty
  a_core: assert property (p_core) else $error("core release window");
  property p_same;
    hard_reset == core_reset;
  endproperty
  a_same: assert property (p_same) else $error("hard and core differ");
  property p_timer;
    $rose(processor_reset_out_n) |-> up_cnt >= TIMER_CYC + 3 && up_cnt <= TIMER_CYC + 12;
  endproperty
  a_timer: assert property (p_timer) else $error("processor release time");
  property p_hs;
    $rose(processor_reset_out_n) |-> hs_seen;
  endproperty
  a_hs: assert property (p_hs) else $error("release without handshake");
  property p_req;
    $rose(hub_handshake_dev == HS_REQ) |-> up_cnt >= TIMER_CYC;
  endproperty
  a_req: assert property (p_req) else $error("handshake overlaps timer");
  property p_ack;
    $rose(hub_handshake_dev == HS_REQ) |=> hub_handshake_lines == HS_ACK;
  endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge");
  property p_por;
    !power_good_in [*5] |-> power_on_reset && hard_reset;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset missing");
  property p_hard;
    (power_good_in && !reset_request_in_n) [*5] |-> hard_reset && !power_on_reset;
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset class wrong");
  property p_hold;
    !reset_request_in_n [*5] |-> !processor_reset_out_n;
  endproperty
  a_hold: assert property (p_hold) else $error("processor not held");
  property p_align;
    $fell(core_reset) |-> $past(clk_align);
  endproperty
  a_align: assert property (p_align) else $error("core release off the common edge");
  c_run: cover property ($rose(processor_reset_out_n));
  c_hs: cover property ($rose(hub_handshake_dev == HS_REQ));
  c_drop: cover property ($fell(power_good_in));
  c_core: cover property ($fell(core_reset));
endmodule

// File: test/tb.sv
// Self-checking bench for the reset sequencer pair
`timescale 1ns/1ps
module tb;
  import por_seq_pkg::*;
  localparam int SH = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic supply_ok = 1'b0;
  logic hub_rst_n, por, hard, core, proc_n, align;
  int   err_count = 0;
  int   comparisons = 0;
  int   t;
  int   m;
  int   a;
  por_link_if link ();
  always #12.5 core_clk = ~core_clk;
  por_companion_hub #(.PWR_CYC(SH), .RST_CYC(SH)) por_companion_hub_inst (.core_clk(core_clk),
    .rst(rst), .supply_ok(supply_ok), .hub_reset_out_n(hub_rst_n), .link(link));
  por_sequencer #(.TIMER_CYC(SH)) por_sequencer_inst (.core_clk(core_clk), .rst(rst),
    .link(link), .power_on_reset(por), .hard_reset(hard), .core_reset(core),
    .processor_reset_out_n(proc_n), .clk_align(align));
  por_monitor #(.TIMER_CYC(SH), .RST_CYC(SH)) por_monitor_inst (.core_clk(core_clk),
    .rst(rst), .power_good_in(link.power_good_in),
    .reset_request_in_n(link.reset_request_in_n), .hub_handshake_dev(link.hub_handshake_dev),
    .hub_handshake_lines(link.hub_handshake_lines), .power_on_reset(por),
    .hard_reset(hard), .core_reset(core), .processor_reset_out_n(proc_n),
    .clk_align(align));

  task automatic close_out();
    $display("Checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input int lo, input int hi, input logic [31:0] got);
    comparisons++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      err_count++;
      $display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
    end
  endtask

  function automatic logic hit(input int sel);
    case (sel)
      0: return link.power_good_in;
      1: return link.reset_request_in_n;
      2: return !core;
      3: return proc_n;
      default: return por;
    endcase
  endfunction

  // Bounded wait in falling-edge steps
  task automatic wait_for(input int sel, output int n);
    n = 0;
    while (hit(sel) !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      $display("BAD wait %0d exp done got timeout", sel);
      close_out();
    end
  endtask

  task automatic power_up();
    supply_ok = 1'b1;
    wait_for(0, t);
    chk("pg delay", SH + 1, SH + 2, t);
    repeat (8) @(negedge core_clk);
    chk("hard", 1, 1, hard);
    chk("por", 0, 0, por);
    chk("proc held", 0, 0, proc_n);
    chk("hub out held", 0, 0, hub_rst_n);
    wait_for(1, t);
    chk("req delay", SH - 8, SH - 8, t);
    chk("hub out rel", 1, 1, hub_rst_n);
    wait_for(2, t);
    chk("core rel", 4, 6, t);
    chk("hard rel", 0, 0, hard);
    wait_for(3, m);
    chk("proc rel", SH + 3, SH + 12, t + m);
    a = 0;
    repeat (CLK_ALIGN_DIV) begin
      a += align;
      @(negedge core_clk);
    end
    chk("align pulses", 1, 1, a);
  endtask

  initial begin
    repeat (10) @(negedge core_clk);
    chk("por in reset", 1, 1, por);
    chk("proc in reset", 0, 0, proc_n);
    rst = 1'b0;
    @(negedge core_clk);
    power_up();
    supply_ok = 1'b0;
    wait_for(4, t);
    chk("por on drop", 1, 5, t);
    chk("proc on drop", 0, 0, proc_n);
    chk("hard on drop", 1, 1, hard);
    chk("align off", 0, 0, align);
    // Drop power again while the processor timer runs
    supply_ok = 1'b1;
    wait_for(1, t);
    repeat (10) @(negedge core_clk);
    supply_ok = 1'b0;
    wait_for(4, t);
    chk("core mid drop", 1, 1, core);
    chk("proc mid drop", 0, 0, proc_n);
    power_up();
    close_out();
  end
endmodule
